// ==== frp_round_post.sv ====
/*
  Round and postprocess stage: rounds a 67-bit intermediate mantissa,
  applies range control, sets flags and condition codes.
  Assumes nonzero mantissas arrive normalized (bit 66 set) and that
  i_ir and i_op are valid in the cycle of i_valid.
*/
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "frp_cfg.svh"
module frp_round_post
  import frp_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Avalon-MM slave.
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Intermediate result in.
  input wire logic i_valid,
  input wire frp_ir_t i_ir,
  input wire frp_op_t i_op,
  // Rounded result out.
  output logic o_valid,
  output frp_res_t o_res,
  output frp_cc_t o_cc,
  output logic [2:0] o_flags
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Bias a signed exponent into 15 bits.
  function automatic logic [14:0] frp_bias(
    input logic [16:0] e
  );
    logic [16:0] b;
    b = e + `FRP_BIAS;
    return b[14:0];
  endfunction : frp_bias

  // Increment decision for one mode.
  function automatic logic frp_inc(
    input frp_mode_t m,
    input logic sg,
    input logic l,
    input logic g,
    input logic r,
    input logic s
  );
    logic x;
    x = g | r | s;
    unique case (m)
      round_nearest: return g & (r | s | l); // RULE10 RULE13
      round_toward_zero: return 1'b0; // RULE11
      round_up_positive: return x & ~sg; // RULE11
      round_down_negative: return x & sg; // RULE11
    endcase
  endfunction : frp_inc

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // Control: mode in [1:0], width in [3:2].
  logic [3:0] ctrl_r;
  // Status: cc and fault status byte.
  frp_cc_t cc_r;
  logic [2:0] fault_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic valid_r;
  frp_res_t res_r;

  frp_mode_t mode_w;
  assign mode_w = frp_mode_t'(ctrl_r[1:0]); // RULE1 RULE2

  // ----------------------------------------
  // Precision select
  // ----------------------------------------
  frp_prec_t prec_w;
  logic [6:0] lp_w;
  logic [16:0] emin_w;
  logic [16:0] emax_w;

  // Pick the boundary from destination.
  always_comb begin
    if (i_op.dest == dest_freg) begin
      // Instruction rounding wins over ctrl.
      if (i_op.ovr == ovr_single) begin
        prec_w = width_single; // RULE7
      end else if (i_op.ovr == ovr_double) begin
        prec_w = width_double; // RULE7
      end else begin
        prec_w = frp_prec_t'(ctrl_r[3:2]); // RULE7
      end
    end else begin
      prec_w = i_op.mem_fmt; // RULE8
    end
  end

  // Boundary and exponent range.
  // Undefined width acts as extended.
  always_comb begin
    unique case (prec_w)
      width_single: begin
        lp_w = `FRP_LSB_S; // RULE3
        emin_w = `FRP_EMIN_S;
        emax_w = `FRP_EMAX_S;
      end
      width_double: begin
        lp_w = `FRP_LSB_D; // RULE3
        emin_w = `FRP_EMIN_D;
        emax_w = `FRP_EMAX_D;
      end
      default: begin
        lp_w = `FRP_LSB_X; // RULE3
        emin_w = `FRP_EMIN_X;
        emax_w = `FRP_EMAX_X;
      end
    endcase
  end

  // ----------------------------------------
  // Underflow, round, overflow
  // ----------------------------------------
  logic [16:0] e_w; // Sign-extended exponent.
  logic [16:0] d_w; // Denormalize distance.
  logic zin_w; // Zero input.
  logic uf_w; // Below normal range.
  logic gross_w; // Nothing left to keep.
  logic [66:0] sh_w; // Shifted mantissa.
  logic lost_w; // Bits shifted out.
  logic [66:0] keep_w; // Kept-bit mask.
  logic lsb_w;
  logic g_w;
  logic r_w;
  logic s_w;
  logic inc_w;
  logic [67:0] sum_w;
  logic carry_w;
  logic [66:0] mr_w; // Rounded mantissa.
  logic [16:0] er_w; // Rounded exponent.
  logic ovf_w;
  logic up_w; // Mode rounds away here.

  // The 67-bit datapath keeps guard, round
  // and sticky under extended rounding.
  always_comb begin
    e_w = {i_ir.exp[15], i_ir.exp}; // RULE22
    zin_w = (i_ir.mant == 67'h0); // RULE14
    // Range check first, before rounding.
    uf_w = !zin_w && ($signed(e_w) < $signed(emin_w)); // RULE4 RULE17
    d_w = emin_w - e_w;
    gross_w = 1'b0;
    sh_w = i_ir.mant;
    lost_w = 1'b0;
    if (uf_w) begin
      if (d_w > `FRP_GROSS) begin
        gross_w = 1'b1;
        sh_w = 67'h0;
        lost_w = 1'b1;
      end else begin
        // Denormalize, folding lost bits.
        sh_w = i_ir.mant >> d_w[6:0]; // RULE18
        lost_w = |(i_ir.mant & ~({67{1'b1}} << d_w[6:0])); // RULE21
      end
    end
    keep_w = {67{1'b1}} << lp_w;
    lsb_w = sh_w[lp_w];
    g_w = sh_w[lp_w - 7'h1];
    r_w = sh_w[lp_w - 7'h2];
    // Sticky: OR of all below round.
    s_w = (|(sh_w & ~({67{1'b1}} << (lp_w - 7'h2)))) | lost_w; // RULE21
    // Denormal that keeps nothing is gross.
    if (uf_w && ((sh_w & keep_w) == 67'h0)) begin
      gross_w = 1'b1;
    end
    inc_w = frp_inc(mode_w, i_ir.sign, lsb_w, g_w, r_w, s_w);
    sum_w = {1'b0, sh_w & keep_w} + (inc_w ? (68'h1 << lp_w) : 68'h0);
    carry_w = sum_w[67];
    // Carry-out: shift right, GRS gone.
    mr_w = carry_w ? sum_w[67:1] : sum_w[66:0]; // RULE12
    er_w = (uf_w ? emin_w : e_w) + {16'h0, carry_w}; // RULE12
    // Overflow last, on the rounded value.
    ovf_w = !uf_w && ($signed(er_w) > $signed(emax_w)); // RULE17 RULE20
    up_w = (mode_w == round_up_positive && !i_ir.sign)
      || (mode_w == round_down_negative && i_ir.sign);
  end

  // ----------------------------------------
  // Result compose
  // ----------------------------------------
  frp_res_t res_w;
  frp_cc_t cc_w;
  logic [2:0] fl_w; // {overflow_flag, underflow_flag, inexact}

  always_comb begin
    res_w.sign = i_ir.sign;
    res_w.exp = frp_bias(er_w); // RULE22
    res_w.mant = mr_w[66:3];
    fl_w = 3'h0;
    cc_w = '{n: i_ir.sign, z: 1'b0, inf: 1'b0, nan: 1'b0};
    if (i_ir.is_nan) begin
      // NaN passes through quiet.
      res_w.exp = `FRP_EXP_MAX;
      res_w.mant = {2'h3, i_ir.mant[64:3]};
      cc_w.nan = 1'b1;
    end else if (i_ir.is_inf) begin
      res_w.exp = `FRP_EXP_MAX; // RULE6
      res_w.mant = 64'h0;
      cc_w.inf = 1'b1;
    end else if (zin_w) begin
      res_w.exp = 15'h0;
      res_w.mant = 64'h0;
      cc_w.z = 1'b1;
    end else if (uf_w) begin
      fl_w[1] = 1'b1; // RULE18
      fl_w[0] = g_w | r_w | s_w; // RULE9
      if (gross_w) begin
        fl_w[0] = 1'b1;
        // Smallest denormal only if the mode
        // rounds away from zero.
        res_w.mant = up_w ? 64'(67'h1 << (lp_w - 7'h3)) : 64'h0; // RULE19
        cc_w.z = !up_w; // RULE19
      end
      // Extended denormals use exponent zero.
      if (prec_w == width_ext || prec_w == width_undef || cc_w.z) begin
        res_w.exp = 15'h0;
      end else begin
        res_w.exp = frp_bias(emin_w);
      end
    end else if (ovf_w) begin
      fl_w[2] = 1'b1; // RULE20
      fl_w[0] = 1'b1; // RULE9
      if (mode_w == round_nearest || up_w) begin
        res_w.exp = `FRP_EXP_MAX; // RULE6 RULE20
        res_w.mant = 64'h0;
        cc_w.inf = 1'b1;
      end else begin
        // Largest mantissa of the precision; exponent emax_w, or FRP_SGL_LRG_EXP for single.
        res_w.mant = keep_w[66:3]; // RULE20
        res_w.exp = frp_bias(emax_w); // RULE4
        if (prec_w == width_single) begin
          res_w.exp = frp_bias(`FRP_SGL_LRG_EXP); // RULE5
        end
      end
    end else begin
      fl_w[0] = g_w | r_w | s_w; // RULE9
    end
  end

  // ----------------------------------------
  // Result and status update
  // ----------------------------------------

  // One cycle from i_valid to o_valid.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valid_r <= 1'b0;
      res_r <= '0;
    end else begin
      valid_r <= i_valid;
      if (i_valid) begin
        res_r <= res_w;
      end
    end
  end

  // Fault byte per op; cc only on request.
  // No software clear, so no race here.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fault_r <= 3'h0;
      cc_r <= '0;
    end else if (i_valid) begin
      fault_r <= fl_w; // RULE9
      if (i_op.upd_cc) begin
        cc_r <= cc_w; // RULE15
      end
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic req_w;
  assign req_w = i_avs_read | i_avs_write;

  // Waitrequest drops for one cycle per
  // request; a held request sees it drop.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !(req_w && wait_r);
    end
  end

  // Read data loads as waitrequest drops.
  // Unmapped reads return zero.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= 32'h0;
    end else if (i_avs_read && wait_r) begin
      rdata_r <= 32'h0;
      if (i_avs_address == `FRP_CTRL_OFS) begin
        rdata_r[3:0] <= ctrl_r;
      end else if (i_avs_address == `FRP_STAT_OFS) begin
        rdata_r[`FRP_CC_LSB +: 4] <= cc_r; // RULE16
        rdata_r[`FRP_INEX_BIT] <= fault_r[0];
        rdata_r[`FRP_UNDERFLOW_FLAG_BIT] <= fault_r[1];
        rdata_r[`FRP_OVERFLOW_FLAG_BIT] <= fault_r[2];
      end
    end
  end

  // Write lands at the completing edge.
  // Status is read only.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= `FRP_CTRL_RST;
    end else if (i_avs_write && !wait_r && i_avs_byteenable[0]) begin
      if (i_avs_address == `FRP_CTRL_OFS) begin
        ctrl_r <= i_avs_writedata[3:0]; // RULE1
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_valid = valid_r;
  assign o_res = res_r;
  assign o_cc = cc_r; // RULE16
  assign o_flags = fault_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  valid_follow_a: assert property (i_valid |=> o_valid) // RULE17
    else $error("result valid missing");
  inex_flag_a: assert property (i_valid && !i_ir.is_nan
    && !i_ir.is_inf && !zin_w && (g_w | r_w | s_w)
    |=> o_flags[0]) // RULE9
    else $error("inexact flag missing");
  tie_even_a: assert property (mode_w == round_nearest
    && g_w && !r_w && !s_w && !lsb_w |-> !inc_w) // RULE13
    else $error("tie not even");
  nearest_up_a: assert property (mode_w == round_nearest
    && g_w && (r_w | s_w) |-> inc_w) // RULE10
    else $error("nearest did not round up");
  directed_sign_a: assert property (inc_w
    && mode_w != round_nearest |-> up_w) // RULE11
    else $error("directed increment wrong sign");
  carry_shift_a: assert property (i_valid && carry_w
    && !uf_w && !ovf_w && !i_ir.is_nan && !i_ir.is_inf
    |=> o_res.mant == 64'h8000000000000000) // RULE12
    else $error("carry not shifted");
  ovf_inf_a: assert property (i_valid && ovf_w
    && mode_w == round_nearest && !i_ir.is_nan && !i_ir.is_inf
    |=> o_flags[2] && o_res.exp == 15'h7FFF
    && o_res.mant == 64'h0) // RULE6
    else $error("overflow not infinity");
  sgl_largest_a: assert property (i_valid && ovf_w
    && prec_w == width_single && mode_w == round_down_negative
    && !i_ir.sign && !i_ir.is_nan && !i_ir.is_inf
    |=> o_res.mant == 64'hFFFFFF0000000000) // RULE5
    else $error("single largest wrong");
  underflow_flag_flag_a: assert property (i_valid && uf_w
    && !i_ir.is_nan && !i_ir.is_inf |=> o_flags[1]) // RULE18
    else $error("underflow flag missing");
  mem_prec_a: assert property (i_valid
    && i_op.dest != dest_freg |-> prec_w == i_op.mem_fmt) // RULE8
    else $error("memory precision wrong");
  wait_one_a: assert property (req_w && wait_r
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest not one cycle");

endmodule : frp_round_post
`default_nettype wire

// ==== frp_cfg.svh ====
/*
  Constants of the float round and postprocess stage.
  Assumes it is included by its bare name from the module.
*/
// Operation
// RULE1 - Four rounding modes chosen by control register
// RULE2 - Mode and width field code assignments
// RULE3 - Round to 24, 53 or 64 bits
// RULE4 - Range check exponent against selected precision
// RULE5 - Single toward-minus overflow gives largest single
// RULE6 - Infinity is max exponent, zero mantissa
// RULE7 - Register destination: width field, instruction overrides
// RULE8 - Memory or integer destination: format decides
// RULE9 - Inexact result sets result-not-exact flag
// RULE10 - Nearest adds one on guard with round/sticky
// RULE11 - Zero chops; directed modes increment by sign
// RULE12 - Carry-out shifts right, bumps exponent
// RULE13 - Nearest ties resolve to even
// RULE14 - Intermediate mantissa is 67 bits
// RULE15 - Condition codes updated after each operation; here only when i_op.upd_cc is set
// RULE16 - Condition codes feed the conditional tests
// RULE17 - Underflow check, then round, then overflow
// RULE18 - Tiny result sets underflow flag, denormalizes
// RULE19 - Gross underflow gives signed zero or smallest
// RULE20 - Overflow gives signed infinity or largest
// RULE21 - Sticky is OR of bits below round
// RULE22 - Exponent 16-bit signed, stored 15-bit biased
`ifndef FRP_CFG_SVH
`define FRP_CFG_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define FRP_CTRL_OFS 4'h0
`define FRP_STAT_OFS 4'h4
`define FRP_CTRL_RST 4'h0
`define FRP_CC_LSB 24
`define FRP_INEX_BIT 8
`define FRP_UNDERFLOW_FLAG_BIT 9
`define FRP_OVERFLOW_FLAG_BIT 10
// ----------------------------------------
// Number formats
// ----------------------------------------
`define FRP_BIAS 17'h03FFF
`define FRP_EXP_MAX 15'h7FFF
`define FRP_SGL_LRG_EXP 17'h000FF
`define FRP_EMIN_X 17'h1C002
`define FRP_EMAX_X 17'h03FFF
`define FRP_EMIN_D 17'h1FC02
`define FRP_EMAX_D 17'h003FF
`define FRP_EMIN_S 17'h1FF82
`define FRP_EMAX_S 17'h0007F
`define FRP_LSB_X 7'h03
`define FRP_LSB_D 7'h0E
`define FRP_LSB_S 7'h2B
`define FRP_GROSS 17'h00042
`endif

// ==== frp_pkg.sv ====
/*
  Types of the float round and postprocess stage.
  Assumes frp_cfg.svh is on the include path.
*/
package frp_pkg;
  // ----------------------------------------
  // Mode, width, destination and override codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    round_nearest = 2'h0,
    round_toward_zero = 2'h1,
    round_down_negative = 2'h2,
    round_up_positive = 2'h3
  } frp_mode_t;
  typedef enum logic [1:0] {
    width_ext = 2'h0,
    width_single = 2'h1,
    width_double = 2'h2,
    width_undef = 2'h3
  } frp_prec_t;
  typedef enum logic [1:0] {
    dest_freg = 2'h0,
    dest_mem = 2'h1,
    dest_intreg = 2'h2
  } frp_dest_t;
  typedef enum logic [1:0] {
    ovr_none = 2'h0,
    ovr_single = 2'h1,
    ovr_double = 2'h2
  } frp_ovr_t;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Intermediate result from the core.
  typedef struct packed {
    logic sign;
    logic is_nan;
    logic is_inf;
    logic [15:0] exp;
    logic [66:0] mant;
  } frp_ir_t;
  // Destination description of the op.
  typedef struct packed {
    frp_dest_t dest;
    frp_prec_t mem_fmt;
    frp_ovr_t ovr;
    logic upd_cc;
  } frp_op_t;
  // Extended format result.
  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [63:0] mant;
  } frp_res_t;
  // Condition codes.
  typedef struct packed {
    logic n;
    logic z;
    logic inf;
    logic nan;
  } frp_cc_t;
endpackage : frp_pkg

// ==== frp_core_model.sv ====
/*
  Behavioural model of the arithmetic core that feeds the rounding stage.
  Assumes the bench calls put or idle once per clock, right after an edge.
*/
`timescale 1ns/10ps
`default_nettype none
module frp_core_model
  import frp_pkg::*;
(
  // Clock.
  input wire logic i_clock,
  // Intermediate result out.
  output logic o_valid,
  output frp_ir_t o_ir,
  output frp_op_t o_op
);
  // Quiet outputs from time zero so the stage never sees an unknown strobe.
  initial begin
    o_valid = 1'b0;
    o_ir = '0;
    o_op = '0;
  end
  // Present one result; the 67-bit mantissa carries guard, round, sticky.
  task automatic put(input frp_ir_t ir, input frp_op_t op);
    @(posedge i_clock);
    o_valid <= 1'b1;
    o_ir <= ir;
    o_op <= op;
  endtask : put
  // Drop the strobe and scramble the data, so stale values are never trusted.
  task automatic idle();
    @(posedge i_clock);
    o_valid <= 1'b0;
    o_ir <= ~o_ir;
  endtask : idle
endmodule : frp_core_model
`default_nettype wire

// ==== frp_round_post_test.sv ====
/*
  Self-checking bench of the rounding stage: table of cases, then extras.
  Assumes the package, the core model and the design are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module frp_round_post_test;
  import frp_pkg::*;
  // One table row: control value, input, expected outputs.
  typedef struct packed {
    logic [3:0] ctl;
    logic sg;
    logic [15:0] ex;
    logic [66:0] mt;
    frp_op_t op;
    frp_res_t res;
    logic [2:0] fl;
    frp_cc_t cc;
  } frp_row_t;
  localparam logic [63:0] one = 64'h8000000000000000;
  localparam logic [14:0] xb = 15'h3FFF;
  localparam frp_op_t op_f = '{dest_freg, width_ext, ovr_none, 1'b1};
  localparam frp_op_t op_d = '{dest_freg, width_ext, ovr_double, 1'b1};
  localparam frp_op_t op_m = '{dest_mem, width_single, ovr_none, 1'b1};
  localparam frp_op_t op_s = '{dest_freg, width_ext, ovr_single, 1'b1};
  localparam frp_op_t op_i = '{dest_intreg, width_double, ovr_none, 1'b1};
  localparam logic [66:0] sgl = {24'h800001, 43'h40000000000};
  localparam frp_res_t sgr = '{1'b0, xb, {24'h800002, 40'h0}};
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_req;
  logic vin;
  frp_ir_t ir;
  frp_op_t op;
  logic vout;
  frp_res_t res;
  frp_cc_t cc;
  logic [2:0] fl;
  logic [31:0] got;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  frp_row_t rows [21];
  // 40 MHz clock.
  always #12.5 i_clock = ~i_clock;
  frp_core_model u_core (.i_clock(i_clock), .o_valid(vin), .o_ir(ir), .o_op(op));
  frp_round_post u_dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_valid(vin), .i_ir(ir),
    .i_op(op), .o_valid(vout), .o_res(res), .o_cc(cc), .o_flags(fl));
  // Compare and count; a mismatch is printed at once.
  task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One Avalon access; waits for waitrequest low, then checks it took two cycles.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_clock);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do begin
      @(posedge i_clock);
      n++;
    end while (wait_req !== 1'b0);
    check("bus latency", 80'(n), 80'h2);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // One operation; the answer is looked at 1 ns after the edge at which the stage takes it.
  task automatic op_run(input frp_ir_t x, input frp_op_t o);
    u_core.put(x, o);
    u_core.idle();
    #1;
    check("o_valid", 80'(vout), 80'h1);
  endtask : op_run
  // Print the counts and the verdict, then stop.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Cut a hang short; the tests need about 150 cycles.
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rows[0] = '{4'h0, 1'b0, 16'h0, {one, 3'h0}, op_f, '{1'b0, xb, one}, 3'h0, 4'h0};
    rows[1] = '{4'h0, 1'b0, 16'h0, {one, 3'h4}, op_f, '{1'b0, xb, one}, 3'h1, 4'h0};
    rows[2] = '{4'h0, 1'b0, 16'h0, {one + 1, 3'h4}, op_f, '{1'b0, xb, one + 2}, 3'h1, 4'h0};
    rows[3] = '{4'h0, 1'b0, 16'h0, {one, 3'h5}, op_f, '{1'b0, xb, one + 1}, 3'h1, 4'h0};
    rows[4] = '{4'h1, 1'b1, 16'h0, {one + 1, 3'h7}, op_f, '{1'b1, xb, one + 1}, 3'h1, 4'h8};
    rows[5] = '{4'h3, 1'b0, 16'h0, {one + 1, 3'h1}, op_f, '{1'b0, xb, one + 2}, 3'h1, 4'h0};
    rows[6] = '{4'h3, 1'b1, 16'h0, {one + 1, 3'h1}, op_f, '{1'b1, xb, one + 1}, 3'h1, 4'h8};
    rows[7] = '{4'h2, 1'b1, 16'h0, {one + 1, 3'h1}, op_f, '{1'b1, xb, one + 2}, 3'h1, 4'h8};
    rows[8] = '{4'h2, 1'b0, 16'h0, {one + 1, 3'h1}, op_f, '{1'b0, xb, one + 1}, 3'h1, 4'h0};
    rows[9] = '{4'h0, 1'b0, 16'h0, {64'hFFFFFFFFFFFFFFFF, 3'h6}, op_f,
                '{1'b0, 15'h4000, one}, 3'h1, 4'h0};
    rows[10] = '{4'h4, 1'b0, 16'h0, sgl, op_f, sgr, 3'h1, 4'h0};
    rows[11] = '{4'h0, 1'b0, 16'h0, {53'h10000000000001, 14'h2000}, op_d,
                 '{1'b0, xb, {53'h10000000000002, 11'h0}}, 3'h1, 4'h0};
    rows[12] = '{4'h8, 1'b0, 16'h0, sgl, op_m, sgr, 3'h1, 4'h0};
    rows[13] = '{4'hC, 1'b0, 16'h0, {one + 1, 3'h4}, op_f, '{1'b0, xb, one + 2}, 3'h1, 4'h0};
    rows[14] = '{4'h6, 1'b0, 16'h0080, {one, 3'h0}, op_f,
                 '{1'b0, 15'h40FE, 64'hFFFFFF0000000000}, 3'h5, 4'h0};
    rows[15] = '{4'h7, 1'b0, 16'hFED4, {one, 3'h0}, op_f,
                 '{1'b0, 15'h3F81, 64'h0000010000000000}, 3'h3, 4'h0};
    rows[16] = '{4'h4, 1'b0, 16'hFF81, {one, 3'h0}, op_f,
                 '{1'b0, 15'h3F81, 64'h4000000000000000}, 3'h2, 4'h0};
    rows[17] = '{4'h8, 1'b0, 16'h0, {53'h10000000000001, 14'h2000}, op_f,
                 '{1'b0, xb, {53'h10000000000002, 11'h0}}, 3'h1, 4'h0};
    rows[18] = '{4'h8, 1'b0, 16'h0, sgl, op_s, sgr, 3'h1, 4'h0};
    rows[19] = '{4'h4, 1'b0, 16'h0, {53'h10000000000001, 14'h2000}, op_i,
                 '{1'b0, xb, {53'h10000000000002, 11'h0}}, 3'h1, 4'h0};
    rows[20] = '{4'h4, 1'b0, 16'h0080, {one, 3'h0}, op_f, '{1'b0, 15'h7FFF, 64'h0}, 3'h5, 4'h2};
    // Reset for five cycles, then look at the idle state.
    repeat (5) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    #1;
    check("waitrequest", 80'(wait_req), 80'h1);
    check("o_flags", 80'(fl), 80'h0);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check("ctrl reset", 80'(got[3:0]), 80'h0);
    // Table of rounding, precision, overflow and underflow cases.
    for (int i = 0; i < 21; i++) begin
      bus(1'b1, 4'h0, {28'h0, rows[i].ctl}, 4'hF);
      op_run('{rows[i].sg, 1'b0, 1'b0, rows[i].ex, rows[i].mt}, rows[i].op);
      check("o_res", 80'(res), 80'(rows[i].res));
      check("o_flags", 80'(fl), 80'(rows[i].fl));
      check("o_cc", 80'(cc), 80'(rows[i].cc));
    end
    // Status is read only; it mirrors the last operation.
    bus(1'b1, 4'h4, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    check("status flags", 80'(got[10:8]), 80'h5);
    check("status cc", 80'(got[27:24]), 80'h2);
    // Control write without byte lane 0 is dropped; unmapped reads give zero.
    bus(1'b1, 4'h0, 32'h5, 4'hF);
    bus(1'b1, 4'h0, 32'hA, 4'h0);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check("ctrl", 80'(got[3:0]), 80'h5);
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    check("unmapped", 80'(got), 80'h0);
    // Gross underflow toward nearest gives a signed zero.
    bus(1'b1, 4'h0, 32'h4, 4'hF);
    op_run('{1'b1, 1'b0, 1'b0, 16'hFED4, {one, 3'h0}}, op_f);
    check("zero sign", 80'({res.sign, res.mant}), 80'({1'b1, 64'h0}));
    check("zero flags", 80'(fl), 80'h3);
    // Reset in mid-run clears results, status and control.
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    @(posedge i_clock);
    #1;
    check("reset res", 80'(res), 80'h0);
    check("reset flags", 80'(fl), 80'h0);
    check("reset cc", 80'(cc), 80'h0);
    check("reset wait", 80'(wait_req), 80'h1);
    @(posedge i_clock);
    i_arst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check("ctrl cleared", 80'(got[3:0]), 80'h0);
    // Back to back; the second op leaves the condition codes alone.
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    u_core.put('{1'b1, 1'b0, 1'b0, 16'h0, {one + 1, 3'h4}}, op_f);
    u_core.put('{1'b0, 1'b0, 1'b0, 16'h0, {one, 3'h0}}, '{dest_freg, width_ext, ovr_none, 1'b0});
    #1;
    check("first res", 80'(res), 80'({1'b1, xb, one + 2}));
    check("first cc", 80'(cc), 80'h8);
    u_core.idle();
    #1;
    check("second valid", 80'(vout), 80'h1);
    check("second res", 80'(res), 80'({1'b0, xb, one}));
    check("kept cc", 80'(cc), 80'h8);
    @(posedge i_clock);
    #1;
    check("valid drop", 80'(vout), 80'h0);
    // Not-a-number and zero inputs.
    op_run('{1'b0, 1'b1, 1'b0, 16'h0, 67'h0}, op_f);
    check("nan cc", 80'(cc), 80'h1);
    check("nan res", 80'(res), 80'({1'b0, 15'h7FFF, 64'hC000000000000000}));
    op_run('{1'b0, 1'b0, 1'b0, 16'h0, 67'h0}, op_f);
    check("zero cc", 80'(cc), 80'h4);
    report_and_stop();
  end
endmodule : frp_round_post_test
`default_nettype wire
